// file: common/listener_pkg.sv
// constants, encodings and state types shared by the bus listener design
// assumes a single 50 MHz system clock and bus lines already synchronous to it
package listener_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACCEPT_NS     = 20000;  // least time one character handshake takes
    localparam int ACCEPT_CYC    = (ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONVERT_NS    = 100000; // converter settling time after a word update
    localparam int CONVERT_CYC   = (CONVERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // widths
    localparam int CHAR_W     = 7;
    localparam int ENTRY_W    = CHAR_W + 1;  // character plus its attention flag
    localparam int DIGIT_W    = 4;
    localparam int ADDR_W     = 5;
    localparam int MAG_W      = 12;
    localparam int WORD_LEN   = 4;
    localparam int FIFO_DEPTH = 8;

    // field positions inside a queued entry
    localparam int ENTRY_ATN_BIT = 7;
    localparam int GROUP_HI      = 6;
    localparam int GROUP_LO      = 5;

    // command encodings
    localparam logic [CHAR_W-1:0]  UNLISTEN_CHAR = 7'h3F;
    localparam logic [1:0]         LISTEN_GROUP  = 2'h1;
    localparam logic [ADDR_W-1:0]  ADDR_NONE     = 5'h1F;

    // digit meanings
    localparam logic [DIGIT_W-1:0] RANGE_HIGH_DIGIT = 4'h2;
    localparam logic [DIGIT_W-1:0] RANGE_LOW_DIGIT  = 4'h1;
    localparam logic [DIGIT_W-1:0] BCD_MAX          = 4'h9;
    localparam logic [1:0]         POS_RANGE        = 2'h0;
    localparam logic [1:0]         POS_MAG_HI       = 2'h1;
    localparam logic [1:0]         POS_MAG_MID      = 2'h2;
    localparam logic [1:0]         POS_MAG_LO       = 2'h3;
    localparam logic [MAG_W-1:0]   MAG_CLAMP        = 12'h000;

    typedef enum logic [1:0] {
        HS_IDLE    = 2'b00,
        HS_HOLD    = 2'b01,
        HS_RELEASE = 2'b10
    } hs_state_type;

    typedef enum logic [0:0] {
        WD_TAKE   = 1'b0,
        WD_SETTLE = 1'b1
    } wd_state_type;

endpackage

// file: verilog/char_fifo.sv
// synchronous first-in first-out buffer for received bus characters
// assumes one clock; flush empties it in one edge
`timescale 1ns/1ps
module char_fifo
    import listener_pkg::*;
#(
    parameter int WIDTH = ENTRY_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    // pointer arithmetic wraps naturally only for power-of-two depths
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("char_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [PTR_W:0]              count;
    } fifo_state_type;

    fifo_state_type st;
    fifo_state_type next_st;
    logic           do_push;
    logic           do_pop;

    // honest flags straight from the occupancy count
    assign in_ready  = (st.count != (PTR_W+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = st.mem[st.rd_ptr];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    // next occupancy, pointers and storage
    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr         = st.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        next_st.count = st.count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
        if (flush) begin
            next_st.wr_ptr = '0;
            next_st.rd_ptr = '0;
            next_st.count  = '0;
        end
    end

    // register the state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// file: verilog/handshake_acceptor.sv
// three-wire acceptor handshake for one listener on the instrument bus
// assumes bus lines are true-asserted and synchronous; nrfd/ndac enables pull lines low
`timescale 1ns/1ps
module handshake_acceptor
    import listener_pkg::*;
#(
    parameter int HOLD_CYCLES = ACCEPT_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              abort,
    input  wire logic              dav,
    input  wire logic              atn,
    input  wire logic [CHAR_W-1:0] data_in,
    input  wire logic              push_ready,
    output logic                   push_valid,
    output logic      [ENTRY_W-1:0] push_data,
    output logic                   nrfd_oe,
    output logic                   ndac_oe
);
    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 1) begin : g_bad_param
        $error("handshake_acceptor: hold time must be at least one cycle");
    end

    typedef struct packed {
        hs_state_type      state;
        logic [CNT_W-1:0]  cnt;
        logic              nrfd;
        logic              ndac;
        logic              valid;
        logic [ENTRY_W-1:0] data;
    } hs_reg_type;

    hs_reg_type st;
    hs_reg_type next_st;

    assign push_valid = st.valid;
    assign push_data  = st.data;
    assign nrfd_oe    = st.nrfd;
    assign ndac_oe    = st.ndac;

    // one character per pass: ready, latch on data valid, hold, release, rearm
    always_comb begin
        next_st       = st;
        next_st.valid = 1'b0;
        case (st.state)
            HS_IDLE: begin
                next_st.ndac = 1'b1;
                next_st.nrfd = !push_ready; // RL1
                if (dav && !st.nrfd) begin
                    next_st.valid = 1'b1;
                    next_st.data  = {atn, data_in}; // RL4
                    next_st.nrfd  = 1'b1;
                    next_st.cnt   = '0;
                    next_st.state = HS_HOLD;
                end
            end
            HS_HOLD: begin
                next_st.cnt = st.cnt + 1'b1;
                if (st.cnt == CNT_W'(HOLD_CYCLES - 1)) begin
                    next_st.ndac  = 1'b0; // RL2
                    next_st.state = HS_RELEASE;
                end
            end
            HS_RELEASE: begin
                // talker withdraws data valid before we claim the next cycle
                if (!dav) begin
                    next_st.ndac  = 1'b1; // RL1
                    next_st.state = HS_IDLE;
                end
            end
            default: begin
                next_st.state = HS_IDLE;
            end
        endcase
        if (abort) begin
            next_st.state = HS_IDLE;
            next_st.valid = 1'b0;
            next_st.nrfd  = 1'b1;
            next_st.ndac  = 1'b1;
        end
    end

    // register the state; lines held asserted in reset so no character slips by
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st       <= '0;
            st.state <= HS_IDLE;
            st.nrfd  <= 1'b1;
            st.ndac  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule

// file: verilog/gpib_dac_word_listener.sv
// listen-only digital front end of a programmable voltage source on an instrument bus
// assumes all bus inputs are true-asserted levels synchronous to clk_sys;
// power_good comes from the supply monitor, address switches are static
`timescale 1ns/1ps

// Function
// RL1 - every character is accepted with a DAV, NRFD, NDAC handshake
// RL2 - one character handshake takes about twenty microseconds
// RL3 - controller sends each word as exactly four consecutive digit characters
// RL4 - characters arrive as seven parallel bits, one per handshake
// RL5 - characters received with ATN asserted are commands, not data
// RL6 - only own listen address and unlisten act; other commands ignored
// RL7 - low five data bits compared with switch address, 31 usable values
// RL8 - own listen address sets listening, lights indicator, enables digit clock
// RL9 - unlisten clears listening, indicator off, digit clock disabled
// RL10 - interface clear resets listening like unlisten
// RL11 - digits captured only while listening and ATN deasserted
// RL12 - first digit selects range, next three give magnitude, MSD first
// RL13 - digit is low four data bits, bit four most significant
// RL14 - each data handshake advances sequencer writing next first-stage position
// RL15 - after fourth digit all four copy to second stage automatically
// RL16 - second stage drives converter and range, holds until next word
// RL17 - magnitude is twelve-bit three-digit BCD, 000 to 999; non-decimal digits still reach magnitude, with digit_error set
// RL18 - range digit two selects high range, one selects low
// RL19 - output clamped low around power transitions until valid word
// RL20 - controller must not add CR, LF or leading spaces
// RL21 - clearing listening returns sequencer to range position
module gpib_dac_word_listener
    import listener_pkg::*;
#(
    parameter int ACCEPT_CYCLES  = ACCEPT_CYC,
    parameter int CONVERT_CYCLES = CONVERT_CYC,
    parameter int QUEUE_DEPTH    = FIFO_DEPTH
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              atn,
    input  wire logic              ifc,
    input  wire logic              dav,
    input  wire logic [CHAR_W-1:0] data_in,
    input  wire logic [ADDR_W-1:0] address_switch,
    input  wire logic              power_good,
    output logic                   nrfd_oe,
    output logic                   ndac_oe,
    output logic                   listening_led,
    output logic      [MAG_W-1:0]  magnitude,
    output logic                   range_high,
    output logic                   range_low,
    output logic                   output_clamp,
    output logic                   word_strobe,
    output logic                   digit_error
);
    localparam int SET_W = $clog2(CONVERT_CYCLES + 1);

    // the settle counter and word layout assume at least one cycle per update
    if (CONVERT_CYCLES < 1) begin : g_bad_param
        $error("gpib_dac_word_listener: settle time must be at least one cycle");
    end

    typedef struct packed {
        wd_state_type                    state;
        logic [SET_W-1:0]                settle_cnt;
        logic                            listening;
        logic [1:0]                      position;
        logic [WORD_LEN-1:0][DIGIT_W-1:0] stage1;
        logic                            stage1_bad;
        logic [MAG_W-1:0]                out_mag;
        logic                            out_high;
        logic                            out_low;
        logic                            clamp;
        logic                            strobe;
        logic                            bad;
    } word_reg_type;

    word_reg_type st;
    word_reg_type next_st;

    // handshake to queue
    logic               push_valid;
    logic               push_ready;
    logic [ENTRY_W-1:0] push_data;

    // queue to word assembler
    logic               pop_valid;
    logic               pop_ready;
    logic [ENTRY_W-1:0] pop_data;

    // decoded view of the entry at the head of the queue
    logic               head_atn;
    logic [CHAR_W-1:0]  head_char;
    logic [DIGIT_W-1:0] head_digit;
    logic               head_is_my_listen;
    logic               head_is_unlisten;
    logic               head_taken;
    logic               take_digit;
    logic               digit_bad;

    // acceptor handshake; interface clear aborts a character in flight
    handshake_acceptor #(
        .HOLD_CYCLES (ACCEPT_CYCLES)
    ) u_acceptor (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .abort       (ifc),
        .dav         (dav),
        .atn         (atn),
        .data_in     (data_in),
        .push_ready  (push_ready),
        .push_valid  (push_valid),
        .push_data   (push_data),
        .nrfd_oe     (nrfd_oe),
        .ndac_oe     (ndac_oe)
    );

    // the queue decouples the bus pace from the converter settling time;
    // when it fills the acceptor keeps NRFD asserted and the talker waits
    char_fifo #(
        .WIDTH     (ENTRY_W),
        .DEPTH     (QUEUE_DEPTH)
    ) u_queue (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .flush     (ifc),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // commands and data share the queue so their order on the bus is kept:
    // data sent before an unlisten still lands, data after it does not
    assign head_atn   = pop_data[ENTRY_ATN_BIT]; // RL5
    assign head_char  = pop_data[CHAR_W-1:0];
    assign head_digit = head_char[DIGIT_W-1:0]; // RL13

    // own listen address: listen group plus five low bits equal to the switches;
    // the all-ones switch setting is the unlisten code and never matches
    assign head_is_my_listen = head_atn
                            && (head_char[GROUP_HI:GROUP_LO] == LISTEN_GROUP)
                            && (head_char[ADDR_W-1:0] == address_switch)
                            && (address_switch != ADDR_NONE); // RL7
    assign head_is_unlisten  = head_atn && (head_char == UNLISTEN_CHAR); // RL6

    // the assembler only draws from the queue while not settling the converter
    assign pop_ready  = (st.state == WD_TAKE);
    assign head_taken = pop_valid && pop_ready;

    // a data character counts as a digit only while listening
    assign take_digit = head_taken && !head_atn && st.listening; // RL11
    assign digit_bad  = (head_digit > BCD_MAX);

    // top outputs come straight from the registered state
    assign listening_led = st.listening;
    assign magnitude     = st.out_mag;
    assign range_high    = st.out_high;
    assign range_low     = st.out_low;
    assign output_clamp  = st.clamp;
    assign word_strobe   = st.strobe;
    assign digit_error   = st.bad;

    // word assembler: listen state, digit sequencer, two latch stages, clamp
    always_comb begin
        next_st        = st;
        next_st.strobe = 1'b0;
        case (st.state)
            WD_TAKE: begin
                if (head_taken && head_atn) begin
                    // any other command is simply dropped after its handshake
                    if (head_is_my_listen) begin
                        next_st.listening = 1'b1; // RL8
                    end else if (head_is_unlisten) begin
                        next_st.listening = 1'b0; // RL9
                        next_st.position  = POS_RANGE; // RL21
                        next_st.stage1_bad = 1'b0;
                    end
                end
                if (take_digit) begin
                    // sequencer steps once per accepted data character
                    next_st.stage1[st.position] = head_digit; // RL14
                    next_st.position            = st.position + 1'b1; // RL14
                    next_st.stage1_bad          = st.stage1_bad || digit_bad;
                    if (st.position == POS_MAG_LO) begin
                        // fourth digit: move the whole word to the output stage
                        next_st.position = POS_RANGE;
                        next_st.stage1_bad = 1'b0;
                        next_st.out_mag  = {st.stage1[POS_MAG_HI],
                                            st.stage1[POS_MAG_MID],
                                            head_digit}; // RL12 RL15
                        next_st.out_high = (st.stage1[POS_RANGE] == RANGE_HIGH_DIGIT); // RL18
                        next_st.out_low  = (st.stage1[POS_RANGE] != RANGE_HIGH_DIGIT); // RL18
                        next_st.bad      = st.stage1_bad || digit_bad; // RL17
                        next_st.strobe   = 1'b1;
                        next_st.clamp    = 1'b0; // RL19
                        next_st.settle_cnt = '0;
                        next_st.state    = WD_SETTLE;
                    end
                end
            end
            WD_SETTLE: begin
                // hold off the next character until the converter has settled;
                // this is what lets the queue fill under a burst of words
                next_st.settle_cnt = st.settle_cnt + 1'b1;
                if (st.settle_cnt == SET_W'(CONVERT_CYCLES - 1)) begin
                    next_st.state = WD_TAKE;
                end
            end
            default: begin
                next_st.state = WD_TAKE;
            end
        endcase

        // interface clear drops listening and any partial word at once
        if (ifc) begin
            next_st.listening  = 1'b0; // RL10
            next_st.position   = POS_RANGE; // RL21
            next_st.stage1_bad = 1'b0;
        end

        // without good power the output stays clamped at the low level and
        // stays so after power returns until a full word has been received
        if (!power_good) begin
            next_st.clamp    = 1'b1; // RL19
            next_st.out_mag  = MAG_CLAMP; // RL19
            next_st.out_high = 1'b0;
            next_st.out_low  = 1'b1;
            next_st.strobe   = 1'b0;
        end
    end

    // register the state; outputs start clamped and the range latch at low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st         <= '0;
            st.state   <= WD_TAKE;
            st.position <= POS_RANGE;
            st.out_mag <= MAG_CLAMP;
            st.out_low <= 1'b1;
            st.clamp   <= 1'b1;
        end else begin
            st <= next_st; // RL16
        end
    end

endmodule

// file: testbench/listener_monitor.sv
// assertions on the listener's bus handshake and output stage
// assumes it is bound to gpib_dac_word_listener and sees only its ports
`timescale 1ns/1ps
module listener_monitor
    import listener_pkg::*;
#(
    parameter int ACCEPT_CYCLES = ACCEPT_CYC
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              atn,
    input wire logic              ifc,
    input wire logic              dav,
    input wire logic [CHAR_W-1:0] data_in,
    input wire logic [ADDR_W-1:0] address_switch,
    input wire logic              power_good,
    input wire logic              nrfd_oe,
    input wire logic              ndac_oe,
    input wire logic              listening_led,
    input wire logic [MAG_W-1:0]  magnitude,
    input wire logic              range_high,
    input wire logic              range_low,
    input wire logic              output_clamp,
    input wire logic              word_strobe,
    input wire logic              digit_error
);
    logic [15:0] hold_cnt;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // edges with ndac asserted since the last take; saturates so long idle spans cannot wrap
    always_ff @(posedge clk_sys) begin
        if (rst || (dav && !nrfd_oe)) begin
            hold_cnt <= 16'h0000;
        end else if (ndac_oe && hold_cnt != 16'hFFFF) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    a_take_raises_nrfd: assert property ((dav && !nrfd_oe) |=> nrfd_oe)
        else $error("nrfd not raised after take");
    a_accept_hold_time: assert property ($fell(ndac_oe) |-> hold_cnt == ACCEPT_CYCLES)
        else $error("ndac released at wrong time");
    a_ndac_waits_dav: assert property ((dav && !ndac_oe && !ifc) |=> !ndac_oe)
        else $error("ndac reasserted while dav high");
    a_ndac_after_drop: assert property ((!dav && !ndac_oe) |=> ndac_oe)
        else $error("ndac not reasserted after dav drop");
    a_ifc_aborts_hs: assert property (ifc |=> (nrfd_oe && ndac_oe))
        else $error("handshake not aborted by clear");
    a_ifc_clears_led: assert property (ifc |-> ##[1:3] !listening_led)
        else $error("listening kept through clear");
    a_output_holds: assert property ($changed(magnitude) |-> (word_strobe || output_clamp))
        else $error("magnitude changed without a word");
    a_strobe_single: assert property (word_strobe |=> !word_strobe)
        else $error("word strobe longer than one cycle");
    a_clamp_on_power: assert property (!power_good |-> ##[0:2] output_clamp)
        else $error("clamp not set on power loss");
    a_clamp_by_word: assert property ($fell(output_clamp) |-> word_strobe)
        else $error("clamp released without a word");
    a_range_one_hot: assert property (range_high ^ range_low)
        else $error("range selects not exclusive");
    a_bcd_flagged: assert property ((word_strobe && (magnitude[11:8] > 4'h9
        || magnitude[7:4] > 4'h9 || magnitude[3:0] > 4'h9)) |-> digit_error)
        else $error("non-decimal digit not flagged");
endmodule

bind gpib_dac_word_listener listener_monitor #(.ACCEPT_CYCLES(ACCEPT_CYCLES))
    listener_monitor_i (.*);

// file: testbench/bus_talker.sv
// talker side of the three-wire handshake, called by the bench
// assumes the listener pulls nrfd/ndac while their enables are high
`timescale 1ns/1ps
module bus_talker
    import listener_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              nrfd_oe,
    input  wire logic              ndac_oe,
    output logic                   dav,
    output logic                   atn,
    output logic      [CHAR_W-1:0] data_in
);
    int gap = 0; // idle cycles before each character

    initial begin
        dav = 1'b0;
        atn = 1'b0;
        data_in = 7'h00;
    end

    // one source cycle; data is inverted once its hold time is over
    task automatic send(input logic cmd, input logic [CHAR_W-1:0] c);
        repeat (gap) @(negedge clk_sys);
        while (nrfd_oe !== 1'b0) @(negedge clk_sys);
        atn = cmd;
        data_in = c;
        dav = 1'b1;
        while (ndac_oe !== 1'b0) @(negedge clk_sys);
        dav = 1'b0;
        data_in = ~c;
    endtask
endmodule

// file: testbench/gpib_dac_word_listener_test.sv
// self-checking bench for the bus listener: words, commands, clears, clamp
// assumes the package, talker model and bound monitor are compiled first
`timescale 1ns/1ps
module gpib_dac_word_listener_test
    import listener_pkg::*;
;
    localparam int ACC = 4;
    localparam int CONV = 200; // long settle so the queue fills and the bus stalls
    logic              clk_sys, rst, ifc, power_good, dav, atn, nrfd_oe, ndac_oe;
    logic              listening_led, range_high, range_low, output_clamp;
    logic              word_strobe, digit_error;
    logic [CHAR_W-1:0] data_in;
    logic [ADDR_W-1:0] address_switch;
    logic [MAG_W-1:0]  magnitude;
    logic [14:0]       exp_q[$];
    logic [31:0]       seed = 32'h0000FC4F;
    int                error_cnt = 0;
    int                check_count = 0;
    int                stall = 0;
    int                max_stall = 0;

    gpib_dac_word_listener #(.ACCEPT_CYCLES(ACC), .CONVERT_CYCLES(CONV), .QUEUE_DEPTH(8))
    gpib_dac_word_listener_i (
        .clk_sys(clk_sys), .rst(rst), .atn(atn), .ifc(ifc), .dav(dav), .data_in(data_in),
        .address_switch(address_switch), .power_good(power_good), .nrfd_oe(nrfd_oe),
        .ndac_oe(ndac_oe), .listening_led(listening_led), .magnitude(magnitude),
        .range_high(range_high), .range_low(range_low), .output_clamp(output_clamp),
        .word_strobe(word_strobe), .digit_error(digit_error));
    bus_talker bus_talker_i (.clk_sys(clk_sys), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe),
        .dav(dav), .atn(atn), .data_in(data_in));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk_word(input logic [14:0] got, input logic [14:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmd(input logic [CHAR_W-1:0] c);
        bus_talker_i.send(1'b1, c);
    endtask

    task automatic digit(input logic [3:0] d);
        bus_talker_i.send(1'b0, {3'h3, d});
    endtask

    // note of the output word: error flag, range selects, magnitude
    task automatic note(input logic [3:0] r, h, t, u);
        exp_q.push_back({(r > 4'h9 || h > 4'h9 || t > 4'h9 || u > 4'h9),
            r == 4'h2, r != 4'h2, h, t, u});
    endtask

    task automatic word(input logic [3:0] r, h, t, u, input bit keep);
        if (keep) note(r, h, t, u);
        digit(r);
        digit(h);
        digit(t);
        digit(u);
    endtask

    // bounded wait for led (sel 0) or clamp (sel 1), then compare
    task automatic flag_is(input bit sel, input logic v);
        int n;
        n = 0;
        while ((sel ? output_clamp : listening_led) !== v && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        chk_flag(sel ? output_clamp : listening_led, v);
    endtask

    // wait until every noted word is out
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        chk_word(15'(exp_q.size()), 15'h0000);
    endtask

    // result side: each word against the oldest note
    always @(posedge clk_sys) begin
        #1;
        if (word_strobe === 1'b1) begin
            chk_word({digit_error, range_high, range_low, magnitude},
                exp_q.size() > 0 ? exp_q.pop_front() : 15'h7FFF);
        end
        stall = (nrfd_oe === 1'b1 && ndac_oe === 1'b1 && dav === 1'b0) ? stall + 1 : 0;
        if (stall > max_stall) max_stall = stall;
    end

    initial begin
        rst = 1'b1;
        ifc = 1'b0;
        power_good = 1'b1;
        address_switch = 5'(rnd() % 31);
        repeat (5) @(negedge clk_sys);
        chk_word({listening_led, range_high, range_low, magnitude}, 15'h1000);
        chk_flag(output_clamp, 1'b1);
        rst = 1'b0;
        word(4'h1, 4'h2, 4'h3, 4'h4, 1'b0);
        cmd({LISTEN_GROUP, address_switch ^ 5'h01});
        word(4'h2, 4'h5, 4'h6, 4'h7, 1'b0);
        flag_is(1'b0, 1'b0);
        cmd({LISTEN_GROUP, address_switch});
        flag_is(1'b0, 1'b1);
        max_stall = 0;
        for (int i = 0; i < 6; i++) begin
            word(4'(i % 3 + 1), 4'(rnd() % 10), 4'(rnd() % 10), 4'(rnd() % 10), 1'b1);
        end
        chk_flag(max_stall > 4 * ACC, 1'b1);
        word(4'h1, 4'h9, 4'hA, 4'hF, 1'b1);
        note(4'h2, 4'h0, 4'h0, 4'h9);
        digit(4'h2);
        digit(4'h0);
        cmd(7'h55);
        digit(4'h0);
        digit(4'h9);
        drain();
        digit(4'h1);
        digit(4'h3);
        cmd(UNLISTEN_CHAR);
        flag_is(1'b0, 1'b0);
        word(4'h2, 4'h1, 4'h1, 4'h1, 1'b0);
        cmd({LISTEN_GROUP, address_switch});
        word(4'h2, 4'h9, 4'h9, 4'h9, 1'b1);
        drain();
        bus_talker_i.gap = 3;
        digit(4'h2);
        ifc = 1'b1;
        repeat (2) @(negedge clk_sys);
        ifc = 1'b0;
        flag_is(1'b0, 1'b0);
        cmd({LISTEN_GROUP, address_switch});
        word(4'h1, 4'h0, 4'h0, 4'h0, 1'b1);
        drain();
        power_good = 1'b0;
        flag_is(1'b1, 1'b1);
        chk_word({listening_led, range_high, range_low, magnitude}, 15'h5000);
        power_good = 1'b1;
        word(4'h2, 4'h4, 4'h5, 4'h6, 1'b1);
        drain();
        chk_flag(output_clamp, 1'b0);
        complete_run();
    end

    // watchdog well above the few thousand cycles needed
    initial begin
        repeat (50000) @(posedge clk_sys);
        error_cnt++;
        complete_run();
    end
endmodule
